// [psq_pkg.sv]
`default_nettype none
package psq_pkg;
  localparam int DW = 16;
  localparam int OFF_W = 7;
  localparam int ADJ_W = 8;
  localparam int RA_W = 3;
  localparam int BC_W = 3;
  localparam int NSH = 3;
  localparam logic [2:0] DEPTH_MAX = 3'h4;
  localparam logic [2:0] RA_PC = 3'h0;
  localparam logic [2:0] RA_LC = 3'h1;
  localparam logic [2:0] RA_SP = 3'h2;
  localparam logic [2:0] RA_REPEAT_COUNTER = 3'h3;
  localparam logic [2:0] RA_ICR = 3'h4;
  localparam int ICR_LP_BIT = 7;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] LC_RST = 16'h0000;
  localparam logic [15:0] REPEAT_COUNTER_RST = 16'h0000;
  localparam logic [15:0] LP_WIN = 16'h0002;
  typedef logic [47:0] psq_lvl_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_JMP = 4'h1,
    OP_CALL = 4'h2,
    OP_BRR = 4'h3,
    OP_CALLR = 4'h4,
    OP_RET = 4'h5,
    OP_RETI = 4'h6,
    OP_RETURN_ADJUST_INSTR = 4'h7,
    OP_REP = 4'h8,
    OP_BLOCK_REPEAT_INSTR = 4'h9,
    OP_BREAK = 4'ha,
    OP_INTR = 4'hb,
    OP_PUSH = 4'hc,
    OP_POP = 4'hd,
    OP_MOVTOP = 4'he
  } psq_op_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_RETA = 2'h1,
    ST_RETW = 2'h3
  } psq_st_e;
endpackage
`default_nettype wire

// [psq_seq.sv]
// Overview of operation
// - next fetch address from seven sources
// - relative branch adds 7-bit offset
// - 16-bit counter and loop counter readable
// - call/interrupt push counter, return restores
// - stack pointer addresses last pushed entry
// - push predecrements, pop postincrements
// - top-of-stack peek keeps stack pointer
// - adjusted return also adds immediate
// - loops branch back with zero overhead
// - count from immediate or register
// - repeat one word up to 65536
// - repeat counter readable by software
// - block loop holds first, last addresses
// - four nested levels, repeat inside each
// - outer levels saved in hidden shadows
// - read-only three-bit nesting counter
// - interrupts may enter loops; one taken mid-repeat ends the repeat
// - break ends the current loop level
// - in-loop flag set while looping
// - software clear abandons all levels
// - clear near loop end waits one pass
// - final pass end reads flag zero
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module psq_seq
  import psq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic step,
  input wire psq_op_e op,
  input wire logic [15:0] target,
  input wire logic [OFF_W-1:0] rel_off,
  input wire logic [15:0] cnt_imm,
  input wire logic [15:0] cnt_reg,
  input wire logic cnt_sel,
  input wire logic [15:0] bk_last,
  input wire logic [ADJ_W-1:0] adj,
  input wire logic [15:0] push_data,
  input wire logic [RA_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [15:0] fetch_addr,
  output logic busy,
  output logic [15:0] stk_addr,
  output logic [15:0] stk_wdata,
  output logic stk_we,
  output logic stk_re,
  input wire logic [15:0] stk_rdata
);
  //////////////////////////////////////////////////////////////////////
  psq_st_e st_r;
  psq_st_e st_nxt;
  logic [15:0] pc_r;
  logic [15:0] sp_r;
  logic [15:0] repeat_counter_r;
  logic rep_act_r;
  logic isr_r;
  logic [15:0] lp_start_r;
  logic [15:0] lp_end_r;
  logic [15:0] lc_r;
  logic [2:0] depth_r;
  logic clr_pend_r;
  psq_lvl_t sh_r [NSH];
  logic busy_r;
  logic [15:0] rdata_r;
  logic [15:0] stk_addr_r;
  logic [15:0] stk_wdata_r;
  logic stk_we_r;
  logic stk_re_r;
  //////////////////////////////////////////////////////////////////////
  wire taking = step && (st_r == ST_RUN);
  wire pc_wr = reg_wr && (reg_addr == RA_PC);
  wire lc_wr = reg_wr && (reg_addr == RA_LC);
  wire sp_wr = reg_wr && (reg_addr == RA_SP);
  wire icr_wr = reg_wr && (reg_addr == RA_ICR);
  wire [15:0] count = cnt_sel ? cnt_reg : cnt_imm;
  wire [15:0] rel_tgt = pc_r + {{(16-OFF_W){rel_off[OFF_W-1]}}, rel_off};
  wire is_ret = (op == OP_RET) || (op == OP_RETI) || (op == OP_RETURN_ADJUST_INSTR);
  wire is_abs = (op == OP_JMP) || (op == OP_CALL) || (op == OP_INTR);
  wire is_rel = (op == OP_BRR) || (op == OP_CALLR);
  wire seq_op = (op == OP_NONE) || (op == OP_PUSH) || (op == OP_POP)
    || (op == OP_MOVTOP);
  wire lp_on = (depth_r != 3'h0);
  // repeat and loop hardware sleep while a handler runs
  wire rep_hold = rep_act_r && !isr_r && (repeat_counter_r != 16'h0000);
  wire at_end = taking && seq_op && lp_on && !isr_r && !rep_hold
    && (pc_r == lp_end_r);
  wire loop_back = at_end && ((lc_r != 16'h0000) || clr_pend_r);
  wire lp_exit = at_end && !loop_back;
  wire brk = taking && (op == OP_BREAK) && lp_on;
  // a fifth level is refused: no free shadow to hold it
  wire lvl_push = taking && (op == OP_BLOCK_REPEAT_INSTR) && (depth_r < DEPTH_MAX);
  wire lvl_pop = lp_exit || brk;
  wire sw_lp_clr = icr_wr && !reg_wdata[ICR_LP_BIT] && lp_on;
  // executing instruction sits one behind the fetch address
  wire [15:0] to_end = lp_end_r - pc_r + 16'h0001;
  wire in_win = (to_end <= LP_WIN);
  wire abandon = (sw_lp_clr && !in_win)
    || (loop_back && clr_pend_r);
  //////////////////////////////////////////////////////////////////////
  // next fetch address
  wire [15:0] seq_pc = rep_hold ? pc_r
    : loop_back ? lp_start_r
    : pc_r + 16'h0001;
  wire [15:0] pc_step = is_ret ? pc_r
    : is_abs ? target
    : is_rel ? rel_tgt
    : brk ? lp_end_r + 16'h0001
    : seq_pc;
  wire [15:0] pc_nxt = pc_wr ? reg_wdata
    : (st_r == ST_RETW) ? stk_rdata
    : taking ? pc_step
    : pc_r;
  //////////////////////////////////////////////////////////////////////
  // stack in data memory, growing downward
  wire push_any = taking && ((op == OP_CALL) || (op == OP_CALLR)
    || (op == OP_INTR) || (op == OP_PUSH));
  wire pop_any = taking && (is_ret || (op == OP_POP));
  wire peek = taking && (op == OP_MOVTOP);
  wire [15:0] sp_dec = sp_r - 16'h0001;
  wire [15:0] sp_inc = sp_r + 16'h0001;
  wire [15:0] sp_adj = (op == OP_RETURN_ADJUST_INSTR)
    ? sp_inc + {{(16-ADJ_W){1'b0}}, adj}
    : sp_inc;
  wire [15:0] sp_nxt = sp_wr ? reg_wdata
    : push_any ? sp_dec
    : pop_any ? sp_adj
    : sp_r;
  wire [15:0] stk_addr_nxt = push_any ? sp_dec : sp_r;
  wire [15:0] stk_wdata_nxt = (op == OP_PUSH) ? push_data : pc_r;
  //////////////////////////////////////////////////////////////////////
  // software view
  wire lp_flag = lp_on;
  wire [15:0] icr_val = {8'h00, lp_flag, 4'h0, depth_r};
  wire [15:0] rd_mux = (reg_addr == RA_PC) ? pc_r
    : (reg_addr == RA_LC) ? lc_r
    : (reg_addr == RA_SP) ? sp_r
    : (reg_addr == RA_REPEAT_COUNTER) ? repeat_counter_r
    : (reg_addr == RA_ICR) ? icr_val
    : 16'h0000;
  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    case (st_r)
      ST_RUN: st_nxt = (taking && is_ret) ? ST_RETA : ST_RUN;
      ST_RETA: st_nxt = ST_RETW;
      ST_RETW: st_nxt = ST_RUN;
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_RUN;
      busy_r <= 1'b0;
      pc_r <= PC_RST;
      sp_r <= SP_RST;
    end
    else
    begin
      st_r <= st_nxt;
      busy_r <= (st_nxt != ST_RUN);
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stk_addr_r <= 16'h0000;
      stk_wdata_r <= 16'h0000;
      stk_we_r <= 1'b0;
      stk_re_r <= 1'b0;
    end
    else
    begin
      stk_addr_r <= stk_addr_nxt;
      stk_wdata_r <= stk_wdata_nxt;
      stk_we_r <= push_any;
      stk_re_r <= pop_any || peek;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////
  // interrupt context and single-instruction repeat
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      isr_r <= 1'b0;
    else if (taking && (op == OP_INTR))
      isr_r <= 1'b1;
    else if (taking && (op == OP_RETI))
      isr_r <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rep_act_r <= 1'b0;
      repeat_counter_r <= REPEAT_COUNTER_RST;
    end
    else if (taking && (op == OP_REP))
    begin
      rep_act_r <= 1'b1;
      repeat_counter_r <= count;
    end
    // an interrupt taken mid-repeat skips the decrement, then falls through and ends the repeat
    else if (taking && rep_hold && (op != OP_INTR))
      repeat_counter_r <= repeat_counter_r - 16'h0001;
    else if (taking && rep_act_r && !isr_r)
      rep_act_r <= 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // block loops: current level plus hidden shadows
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lp_start_r <= 16'h0000;
      lp_end_r <= 16'h0000;
      lc_r <= LC_RST;
    end
    else
    begin
      // a bus write to the counter must not lose a level's addresses
      if (lvl_push)
      begin
        lp_start_r <= pc_r;
        lp_end_r <= bk_last;
      end
      else if (lvl_pop)
      begin
        lp_start_r <= sh_r[0][47:32];
        lp_end_r <= sh_r[0][31:16];
      end
      if (lc_wr)
        lc_r <= reg_wdata;
      else if (lvl_push)
        lc_r <= count;
      else if (lvl_pop)
        lc_r <= sh_r[0][15:0];
      else if (loop_back && !clr_pend_r)
        lc_r <= lc_r - 16'h0001;
    end
  end

  generate
    for (genvar i = 0; i < NSH; i++)
    begin : g_sh
      psq_lvl_t up_w;
      psq_lvl_t dn_w;
      if (i == 0)
      begin : g_first
        assign up_w = {lp_start_r, lp_end_r, lc_r};
      end
      else
      begin : g_mid
        assign up_w = sh_r[i-1];
      end
      if (i == NSH - 1)
      begin : g_last
        assign dn_w = '0;
      end
      else
      begin : g_low
        assign dn_w = sh_r[i+1];
      end
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          sh_r[i] <= '0;
        else if (lvl_push)
          sh_r[i] <= up_w;
        else if (lvl_pop)
          sh_r[i] <= dn_w;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      depth_r <= 3'h0;
      clr_pend_r <= 1'b0;
    end
    else if (abandon)
    begin
      depth_r <= 3'h0;
      clr_pend_r <= 1'b0;
    end
    else
    begin
      if (sw_lp_clr)
        clr_pend_r <= 1'b1;
      if (lvl_push)
        depth_r <= depth_r + 3'h1;
      else if (lvl_pop)
        depth_r <= depth_r - 3'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  assign reg_rdata = rdata_r;
  assign fetch_addr = pc_r;
  assign busy = busy_r;
  assign stk_addr = stk_addr_r;
  assign stk_wdata = stk_wdata_r;
  assign stk_we = stk_we_r;
  assign stk_re = stk_re_r;
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_rel_target: assert property (
    taking && is_rel && !pc_wr |=> pc_r == $past(pc_r)
      + {{9{$past(rel_off[6])}}, $past(rel_off)})
    else $error("relative target wrong");
  a_push_predec: assert property (
    taking && (op == OP_PUSH) && !sp_wr |=> stk_we_r
      && (stk_addr_r == $past(sp_r) - 16'h0001) && (sp_r == stk_addr_r))
    else $error("push not predecrement");
  a_pop_postinc: assert property (
    taking && (op == OP_POP) && !sp_wr |=> stk_re_r
      && (stk_addr_r == $past(sp_r)) && (sp_r == $past(sp_r) + 16'h0001))
    else $error("pop not postincrement");
  a_peek_keep: assert property (
    peek && !sp_wr |=> stk_re_r && (sp_r == $past(sp_r)))
    else $error("peek moved stack pointer");
  a_call_push: assert property (
    taking && (op == OP_CALL) |=> stk_we_r
      && (stk_wdata_r == $past(pc_r)) && busy_r == 1'b0)
    else $error("call did not push counter");
  a_ret_restore: assert property (
    (taking && (op == OP_RET)) ##2 !pc_wr |=> pc_r == $past(stk_rdata))
    else $error("return did not restore counter");
  a_rep_hold: assert property (
    taking && rep_hold && seq_op && !pc_wr |=> (pc_r == $past(pc_r))
      && (repeat_counter_r == $past(repeat_counter_r) - 16'h0001))
    else $error("repeat did not hold fetch");
  a_loop_back: assert property (
    loop_back && !clr_pend_r && !pc_wr && !lc_wr && !abandon
      |=> (pc_r == $past(lp_start_r)) && (lc_r == $past(lc_r) - 16'h0001))
    else $error("loop did not branch back");
  a_depth_max: assert property (
    depth_r <= DEPTH_MAX)
    else $error("nesting depth overflow");
  a_sw_clear: assert property (
    sw_lp_clr && !in_win |=> (depth_r == 3'h0) ##1 (depth_r == 3'h0)
      || $past(lvl_push))
    else $error("software clear kept loops");
  a_flag_read: assert property (
    reg_rd && (reg_addr == RA_ICR) |=> reg_rdata[ICR_LP_BIT]
      == ($past(depth_r) != 3'h0))
    else $error("in-loop flag mismatch");
  a_break_exit: assert property (
    brk && !pc_wr && !abandon |=> (pc_r == $past(lp_end_r) + 16'h0001)
      && (depth_r == $past(depth_r) - 3'h1))
    else $error("break did not leave level");
  a_ret_adjust: assert property (
    taking && (op == OP_RETURN_ADJUST_INSTR) && !sp_wr
      |=> sp_r == $past(sp_r) + 16'h0001 + {8'h00, $past(adj)})
    else $error("adjusted return stack pointer wrong");

  c_deep_nest: cover property (taking && (op == OP_BLOCK_REPEAT_INSTR)
    && (depth_r == 3'h3));
  c_outer_exit: cover property (lp_exit && (depth_r == 3'h1));
  c_rep_run: cover property (taking && rep_hold ##1 taking && rep_hold);
  c_deferred: cover property (sw_lp_clr && in_win);
endmodule // psq_seq
`default_nettype wire

// [psq_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module psq_mem
(
  input wire logic ref_clk,
  input wire logic [15:0] stk_addr,
  input wire logic [15:0] stk_wdata,
  input wire logic stk_we,
  input wire logic stk_re,
  output logic [15:0] stk_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] rd_r = 16'ha5c3;
  assign stk_rdata = rd_r;
  // data stand one cycle, then flip so a late sample never matches
  always_ff @(posedge ref_clk)
  begin
    if (stk_we)
      mem[stk_addr[7:0]] <= stk_wdata;
    if (stk_re)
      rd_r <= mem[stk_addr[7:0]];
    else
      rd_r <= ~rd_r;
  end
endmodule // psq_mem
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import psq_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic step = 1'b0;
  psq_op_e op = OP_NONE;
  logic [15:0] target = 16'h0000;
  logic [OFF_W-1:0] rel_off = 7'h00;
  logic [15:0] cnt_imm = 16'h0000;
  logic [15:0] cnt_reg = 16'h0000;
  logic cnt_sel = 1'b0;
  logic [15:0] bk_last = 16'h0000;
  logic [ADJ_W-1:0] adj = 8'h00;
  logic [15:0] push_data = 16'h0000;
  logic [RA_W-1:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, fetch_addr, stk_addr, stk_wdata, stk_rdata;
  logic busy, stk_we, stk_re;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] p;

  psq_seq dut (.ref_clk, .rst, .step, .op, .target, .rel_off, .cnt_imm,
    .cnt_reg, .cnt_sel, .bk_last, .adj, .push_data, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .fetch_addr, .busy, .stk_addr,
    .stk_wdata, .stk_we, .stk_re, .stk_rdata);
  psq_mem mem (.ref_clk, .stk_addr, .stk_wdata, .stk_we, .stk_re,
    .stk_rdata);

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // every operand rides on the step edge; ends mid-cycle so outputs settle
  task automatic st(input psq_op_e o, input logic [15:0] t = 16'h0000,
                    input logic [15:0] n = 16'h0000, input logic s = 1'b0);
    @(posedge ref_clk);
    step <= 1'b1;
    op <= o;
    target <= t;
    bk_last <= t;
    push_data <= t;
    cnt_sel <= s;
    cnt_imm <= s ? 16'h0000 : n;
    cnt_reg <= s ? n : 16'h0000;
    adj <= n[7:0];
    rel_off <= n[6:0];
    @(posedge ref_clk);
    step <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 8; a++)
      rd(a[2:0], 16'h0000);
    wr(3'h3, 16'h00ff);
    rd(3'h3, 16'h0000);
    wr(3'h0, 16'h0123);
    @(negedge ref_clk);
    chk(fetch_addr, 16'h0123);
  endtask

  task automatic t_call(input psq_op_e c, input psq_op_e r,
                        input logic [15:0] n);
    wr(3'h2, 16'h0040);
    @(negedge ref_clk);
    p = fetch_addr;
    st(c, 16'h0100);
    chk(fetch_addr, 16'h0100);
    chk(stk_we ? stk_addr : 16'hffff, 16'h003f);
    chk(stk_wdata, p);
    rd(3'h2, 16'h003f);
    st(r, 16'h0000, n);
    chk(stk_re ? stk_addr : 16'hffff, 16'h003f);
    chk(busy ? 16'h0001 : 16'h0000, 16'h0001);
    repeat (2) @(negedge ref_clk);
    chk(fetch_addr, p);
    rd(3'h2, 16'h0040 + n);
  endtask

  task automatic t_stack();
    st(OP_PUSH, 16'h1234);
    chk(stk_we ? stk_addr : 16'hffff, 16'h003f);
    chk(stk_wdata, 16'h1234);
    st(OP_MOVTOP);
    chk(stk_re ? stk_addr : 16'hffff, 16'h003f);
    rd(3'h2, 16'h003f);
    st(OP_POP);
    chk(stk_re ? stk_addr : 16'hffff, 16'h003f);
    rd(3'h2, 16'h0040);
  endtask

  task automatic t_brr();
    p = fetch_addr;
    st(OP_BRR, 16'h0000, 16'h007e);
    chk(fetch_addr, p - 16'h0002);
    st(OP_BRR, 16'h0000, 16'h003f);
    chk(fetch_addr, p + 16'h003d);
    // relative call: offset 0x40 is -64, return address pushed
    st(OP_CALLR, 16'h0000, 16'h0040);
    chk(fetch_addr, p - 16'h0003);
    chk(stk_we ? stk_wdata : 16'hffff, p + 16'h003d);
  endtask

  task automatic t_rep(input logic s);
    st(OP_JMP, 16'h0200);
    st(OP_REP, 16'h0000, 16'h0002, s);
    chk(fetch_addr, 16'h0201);
    rd(3'h3, 16'h0002);
    repeat (2)
    begin
      st(OP_NONE);
      chk(fetch_addr, 16'h0201);
    end
    rd(3'h3, 16'h0000);
    st(OP_NONE);
    chk(fetch_addr, 16'h0202);
  endtask

  task automatic t_bk();
    logic [15:0] sq [5] = '{16'h0302, 16'h0300, 16'h0301, 16'h0302,
                            16'h0303};
    st(OP_JMP, 16'h0300);
    st(OP_BLOCK_REPEAT_INSTR, 16'h0302, 16'h0001);
    rd(3'h4, 16'h0081);
    rd(3'h1, 16'h0001);
    foreach (sq[i])
    begin
      st(OP_NONE);
      chk(fetch_addr, sq[i]);
    end
    rd(3'h4, 16'h0000);
  endtask

  // d: clear lands inside the last two body words, so one more pass
  task automatic t_lp(input logic d);
    st(OP_JMP, 16'h0400);
    st(OP_BLOCK_REPEAT_INSTR, 16'h0405, 16'h0003);
    if (d)
      repeat (4) st(OP_NONE);
    wr(3'h4, 16'h0000);
    if (d)
    begin
      st(OP_NONE);
      chk(fetch_addr, 16'h0400);
    end
    repeat (4 + d) st(OP_NONE);
    chk(fetch_addr, 16'h0405);
    st(OP_NONE);
    chk(fetch_addr, 16'h0406);
    rd(3'h4, 16'h0000);
  endtask

  task automatic t_nest();
    st(OP_JMP, 16'h0600);
    for (int k = 1; k < 6; k++)
      st(OP_BLOCK_REPEAT_INSTR, 16'h06ff, 16'(k));
    chk(fetch_addr, 16'h0605);
    rd(3'h4, 16'h0084);
    rd(3'h1, 16'h0004);
    st(OP_BREAK);
    chk(fetch_addr, 16'h0700);
    rd(3'h4, 16'h0083);
    rd(3'h1, 16'h0003);
    // back inside the body, clear of the last two words
    st(OP_JMP, 16'h0610);
    wr(3'h4, 16'h0000);
    rd(3'h4, 16'h0000);
  endtask

  // mid-run reset: counter and stack pointer return to zero
  task automatic t_rst();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk(fetch_addr, 16'h0000);
    rd(3'h2, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("errors %0d in %0d checks", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // whole run needs a few hundred cycles; ceiling leaves ample slack
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_call(OP_CALL, OP_RET, 16'h0000);
    t_stack();
    t_call(OP_INTR, OP_RETI, 16'h0000);
    t_call(OP_CALL, OP_RETURN_ADJUST_INSTR, 16'h0005);
    t_brr();
    t_rep(1'b0);
    t_rep(1'b1);
    t_bk();
    t_lp(1'b0);
    t_lp(1'b1);
    t_nest();
    t_rst();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
